// ===== core/mrs_cfg.svh
// Constants for the reset sequencer: register offsets, reset values, timing.
// Assumes inclusion by core/mrs_reset_seq.sv and the bench only; core/mrs_pkg.sv does not include it.
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

// ----------------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------------
`define MRS_OFS_CTRL 12'h000
`define MRS_OFS_STAT 12'h004
`define MRS_OFS_CAUSE 12'h008
`define MRS_OFS_VECT 12'h00C
`define MRS_OFS_DELAY 12'h010

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MRS_CTRL_LVD_EN 0
`define MRS_CTRL_WD_SWRST 1
`define MRS_CTRL_RETURN_FROM_INTERRUPT 2
`define MRS_CTRL_PEND 3

// ----------------------------------------------------------------------------
// Reset values of the peripheral registers and the reset vector, loaded on reset
// ----------------------------------------------------------------------------
`define MRS_RST_ZERO 8'h00
`define MRS_RST_ARSC0 8'h02
`define MRS_RST_WDCNT 8'hFE
`define MRS_RST_PRESC 8'h7F
`define MRS_RST_ADCR 8'h40
`define MRS_RESET_VECTOR 12'hFFE

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MRS_STAB_CYCLES 4096
`define MRS_PIN_STRETCH_CYCLES 16

`endif

// ===== core/mrs_pkg.sv
// Types shared by the reset sequencer and its bench.
// Assumes the constants header sits beside it.
package mrs_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    MRS_HOLD = 5'b00001,
    MRS_STRETCH = 5'b00010,
    MRS_STAB = 5'b00100,
    MRS_INIT = 5'b01000,
    MRS_RUN = 5'b10000
  } mrs_state_t;

  // --------------------------------------------------------------------------
  // Reset values presented to the peripherals
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] port_data;
    logic [7:0] port_dir;
    logic [7:0] port_opt;
    logic [7:0] ar_sc0;
    logic [7:0] ar_ctrl;
    logic [7:0] misc;
    logic [7:0] spi_ctrl;
    logic [7:0] wd_counter;
    logic [7:0] tmr_presc;
    logic [7:0] adc_ctrl;
  } mrs_init_vals_t;

  // --------------------------------------------------------------------------
  // Reset cause flags
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic swrst;
    logic low_voltage_detector;
    logic wdog;
    logic por;
    logic pin;
  } mrs_cause_t;

endpackage

// ===== core/mrs_reset_seq.sv
// Reset sequencer: merges pin, power-on, watchdog, low-voltage and software
// resets, times a stabilisation delay and drives the initialisation outputs.
// Assumes one clock (main or auxiliary oscillator, muxed outside) and an APB master.
`include "mrs_cfg.svh"

module mrs_reset_seq #(
  parameter int STAB_CYCLES = `MRS_STAB_CYCLES,
  parameter int STRETCH_CYCLES = `MRS_PIN_STRETCH_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic RESET_N_IN,
  input wire logic POR_DETECT,
  input wire logic LVD_BELOW_REF,
  input wire logic LVD_ABOVE_POR_REF,
  input wire logic WDOG_END_COUNT,
  input wire logic MAIN_OSC_RUNNING,
  input wire logic CPU_STOP_MODE,
  input wire logic RETURN_FROM_INTERRUPT_DONE,
  input wire logic IRQ_PENDING,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic RESET_N_OUT,
  output logic RESET_N_OE,
  output logic CORE_HALT,
  output logic IO_PULLUP_FORCE,
  output logic OSC_RESTART,
  output logic STACK_CLEAR,
  output logic [11:0] PROGRAM_COUNTER_LOAD,
  output logic PC_LOAD_STROBE,
  output logic NMI_MODE,
  output logic SERVICE_PENDING,
  output logic WDOG_RELOAD,
  output logic PERIPH_LOAD,
  output mrs_pkg::mrs_init_vals_t PERIPH_INIT,
  output mrs_pkg::mrs_cause_t RESET_CAUSE
);
  import mrs_pkg::*;

  function automatic logic [31:0] rd_byte(input logic [7:0] v);
    rd_byte = {24'h000000, v};
  endfunction

  // --------------------------------------------------------------------------
  // Pin and analog input synchronisers
  // --------------------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [1:0] echo_q;

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      echo_q <= 2'b11;
    end
    else if (CLK_EN)
    begin
      // Pin synchronised before use, SYS_RST asserts asynchronously
      sync1_q <= {~RESET_N_IN, POR_DETECT, LVD_BELOW_REF, LVD_ABOVE_POR_REF, MAIN_OSC_RUNNING};
      sync2_q <= sync1_q;
      echo_q <= {echo_q[0], RESET_N_OE};
    end
  end

  logic pin_low;
  logic por_s;
  logic lvd_low_s;
  logic lvd_ok_s;
  logic osc_ok_s;
  assign pin_low = sync2_q[4];
  assign por_s = sync2_q[3];
  assign lvd_low_s = sync2_q[2];
  assign lvd_ok_s = sync2_q[1];
  assign osc_ok_s = sync2_q[0];

  // Our own pull-down reads back until two cycles after release; counting it as
  // a pin reset would make the pin oscillate. A press inside that window is missed.
  logic pin_ext;
  assign pin_ext = pin_low && !RESET_N_OE && !(|echo_q);

  // --------------------------------------------------------------------------
  // Control registers and sequencer state
  // --------------------------------------------------------------------------
  localparam int CW = $clog2(STAB_CYCLES + STRETCH_CYCLES + 1);

  mrs_state_t state_q;
  mrs_state_t state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic lvd_en_q;
  logic lvd_en_d;
  logic swrst_bit_q;
  logic swrst_bit_d;
  logic lvd_hold_q;
  logic lvd_hold_d;
  logic stop_seen_q;
  logic stop_seen_d;
  mrs_cause_t cause_q;
  mrs_cause_t cause_d;
  logic nmi_q;
  logic nmi_d;
  logic svc_q;
  logic svc_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  logic apb_wr;
  logic apb_rd;
  logic sw_reset;
  logic int_src;
  logic any_src;
  assign apb_wr = PSEL && PENABLE && PWRITE && !pready_q;
  assign apb_rd = PSEL && PENABLE && !PWRITE && !pready_q;
  // Clearing the software-reset bit resets at once
  assign sw_reset = apb_wr && (PADDR == `MRS_OFS_CTRL) && !PWDATA[`MRS_CTRL_WD_SWRST];
  // Internal sources, low-voltage gated by its option
  assign int_src = por_s || WDOG_END_COUNT || sw_reset || (lvd_en_q && lvd_low_s);
  assign any_src = int_src || pin_ext;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    lvd_hold_d = lvd_hold_q;
    stop_seen_d = stop_seen_q;
    cause_d = cause_q;
    // Causes clear by writing ones; a cause raised in the same cycle still sets
    if (apb_wr && (PADDR == `MRS_OFS_CAUSE))
      cause_d = cause_q & ~mrs_cause_t'(PWDATA[4:0]);
    nmi_d = nmi_q;
    svc_d = 1'b0;
    // Low voltage latches a static hold until the higher power-on reference
    if (lvd_en_q && lvd_low_s)
      lvd_hold_d = 1'b1;
    else if (lvd_ok_s)
      lvd_hold_d = 1'b0;
    if (any_src || lvd_hold_q)
    begin
      // Any source restarts the whole sequence, whatever the mode
      state_d = MRS_HOLD;
      cnt_d = '0;
      cause_d.pin = cause_d.pin | pin_ext;
      cause_d.por = cause_d.por | por_s;
      cause_d.wdog = cause_d.wdog | WDOG_END_COUNT;
      cause_d.low_voltage_detector = cause_d.low_voltage_detector | (lvd_en_q & lvd_low_s);
      cause_d.swrst = cause_d.swrst | sw_reset;
      if (state_q == MRS_RUN)
        stop_seen_d = CPU_STOP_MODE;
    end
    else
    begin
      unique case (state_q)
        MRS_HOLD:
        begin
          // Stays here while pin low; release waits for a running oscillator
          if (osc_ok_s)
          begin
            state_d = MRS_STRETCH;
            cnt_d = '0;
          end
        end
        MRS_STRETCH:
        begin
          // Extends a short pin pulse to a minimum reset length
          cnt_d = CW'(cnt_q + 1'b1);
          if (cnt_q >= CW'(STRETCH_CYCLES - 1))
          begin
            state_d = MRS_STAB;
            cnt_d = '0;
          end
        end
        MRS_STAB:
        begin
          // Stabilisation delay, then initialisation
          cnt_d = CW'(cnt_q + 1'b1);
          if (cnt_q >= CW'(STAB_CYCLES - 1))
          begin
            state_d = MRS_INIT;
            nmi_d = 1'b1;
          end
        end
        MRS_INIT:
        begin
          state_d = MRS_RUN;
          stop_seen_d = 1'b0;
        end
        MRS_RUN:
        begin
          // Return from interrupt leaves non-maskable mode
          if (nmi_q && RETURN_FROM_INTERRUPT_DONE)
          begin
            nmi_d = 1'b0;
            svc_d = IRQ_PENDING;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // APB slave: one wait state, every access answered
  // --------------------------------------------------------------------------
  always_comb
  begin
    lvd_en_d = lvd_en_q;
    swrst_bit_d = swrst_bit_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (any_src)
      swrst_bit_d = 1'b1;
    if (apb_wr)
    begin
      pready_d = 1'b1;
      unique case (PADDR)
        `MRS_OFS_CTRL:
        begin
          lvd_en_d = PWDATA[`MRS_CTRL_LVD_EN];
          if (PWDATA[`MRS_CTRL_WD_SWRST])
            swrst_bit_d = 1'b1;
        end
        `MRS_OFS_CAUSE:;
        default: pslverr_d = 1'b1;
      endcase
    end
    else if (apb_rd)
    begin
      pready_d = 1'b1;
      unique case (PADDR)
        `MRS_OFS_CTRL: prdata_d = {28'h0000000, IRQ_PENDING, nmi_q, swrst_bit_q, lvd_en_q};
        `MRS_OFS_STAT: prdata_d = {27'h0000000, state_q};
        `MRS_OFS_CAUSE: prdata_d = rd_byte({3'h0, cause_q});
        `MRS_OFS_VECT: prdata_d = {20'h00000, `MRS_RESET_VECTOR};
        `MRS_OFS_DELAY: prdata_d = 32'(STAB_CYCLES);
        default:
        begin
          prdata_d = 32'h00000000;
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q <= MRS_HOLD;
      cnt_q <= '0;
      lvd_en_q <= 1'b0;
      swrst_bit_q <= 1'b1;
      lvd_hold_q <= 1'b0;
      stop_seen_q <= 1'b0;
      cause_q <= 5'b00010;
      nmi_q <= 1'b0;
      svc_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      lvd_en_q <= lvd_en_d;
      swrst_bit_q <= swrst_bit_d;
      lvd_hold_q <= lvd_hold_d;
      stop_seen_q <= stop_seen_d;
      cause_q <= cause_d;
      nmi_q <= nmi_d;
      svc_q <= svc_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  logic in_reset_d;
  mrs_init_vals_t init_vals;
  assign in_reset_d = (state_d != MRS_RUN) && (state_d != MRS_INIT);

  always_comb
  begin
    init_vals.port_data = `MRS_RST_ZERO;
    init_vals.port_dir = `MRS_RST_ZERO;
    init_vals.port_opt = `MRS_RST_ZERO;
    init_vals.ar_sc0 = `MRS_RST_ARSC0;
    init_vals.ar_ctrl = `MRS_RST_ZERO;
    init_vals.misc = `MRS_RST_ZERO;
    init_vals.spi_ctrl = `MRS_RST_ZERO;
    init_vals.wd_counter = `MRS_RST_WDCNT;
    init_vals.tmr_presc = `MRS_RST_PRESC;
    init_vals.adc_ctrl = `MRS_RST_ADCR;
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RESET_N_OUT <= 1'b0;
      RESET_N_OE <= 1'b1;
      CORE_HALT <= 1'b1;
      IO_PULLUP_FORCE <= 1'b1;
      OSC_RESTART <= 1'b1;
      STACK_CLEAR <= 1'b1;
      PROGRAM_COUNTER_LOAD <= `MRS_RESET_VECTOR;
      PC_LOAD_STROBE <= 1'b0;
      NMI_MODE <= 1'b0;
      SERVICE_PENDING <= 1'b0;
      WDOG_RELOAD <= 1'b1;
      PERIPH_LOAD <= 1'b1;
      // Load is high in reset, so the values it qualifies must already be right
      PERIPH_INIT <= {`MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ARSC0, `MRS_RST_ZERO,
        `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_WDCNT, `MRS_RST_PRESC, `MRS_RST_ADCR};
      RESET_CAUSE <= 5'b00010;
    end
    else if (CLK_EN)
    begin
      // Only pull low, never drive high: wired-AND with the board
      RESET_N_OUT <= 1'b0;
      RESET_N_OE <= int_src || lvd_hold_d;
      CORE_HALT <= in_reset_d;
      IO_PULLUP_FORCE <= in_reset_d;
      // Oscillator restarted on entry, also from stop
      OSC_RESTART <= (state_d == MRS_HOLD);
      STACK_CLEAR <= in_reset_d;
      PROGRAM_COUNTER_LOAD <= `MRS_RESET_VECTOR;
      PC_LOAD_STROBE <= (state_d == MRS_INIT);
      NMI_MODE <= nmi_d;
      SERVICE_PENDING <= svc_d;
      WDOG_RELOAD <= in_reset_d;
      // Only the listed registers are loaded; EEPROM has no path here
      PERIPH_LOAD <= in_reset_d;
      PERIPH_INIT <= init_vals;
      RESET_CAUSE <= cause_q;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  logic unused_stop;
  assign unused_stop = stop_seen_q;

endmodule

// ===== sim/mrs_board.sv
// Application board: reset push switch and pull-up on the reset pin.
// Assumes the device only ever pulls the pin low.
module mrs_board (
  input wire logic press,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-AND: either party pulls low, otherwise the pull-up wins
  assign pin = (press || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
endmodule

// ===== sim/mrs_seq_chk.sv
// Checker for the reset sequencer: reset outputs and release timing.
// Bound to mrs_reset_seq; sees its ports only, one clock domain.
module mrs_seq_chk #(
  parameter int STAB_CYCLES = 8
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic RESET_N_IN,
  input wire logic POR_DETECT,
  input wire logic WDOG_END_COUNT,
  input wire logic RETURN_FROM_INTERRUPT_DONE,
  input wire logic IRQ_PENDING,
  input wire logic RESET_N_OUT,
  input wire logic RESET_N_OE,
  input wire logic CORE_HALT,
  input wire logic IO_PULLUP_FORCE,
  input wire logic OSC_RESTART,
  input wire logic STACK_CLEAR,
  input wire logic [11:0] PROGRAM_COUNTER_LOAD,
  input wire logic PC_LOAD_STROBE,
  input wire logic NMI_MODE,
  input wire logic SERVICE_PENDING,
  input wire logic WDOG_RELOAD,
  input wire logic PERIPH_LOAD,
  input wire mrs_pkg::mrs_init_vals_t PERIPH_INIT
);
  timeunit 1ns;
  timeprecision 1ps;
  import mrs_pkg::*;
  localparam mrs_init_vals_t INIT_EXP = 80'h00000002000000FE7F40;
  logic [15:0] halt_cnt_q;
  logic [15:0] halt_cnt_d;

  // ------------------------------------------------------------
  // Length of the current reset; saturates so a long hold cannot wrap
  // ------------------------------------------------------------
  always_comb
    halt_cnt_d = !CORE_HALT ? 16'h0000 : (&halt_cnt_q ? halt_cnt_q : halt_cnt_q + 16'h0001);

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
    if (SYS_RST)
      halt_cnt_q <= 16'h0000;
    else
      halt_cnt_q <= halt_cnt_d;

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence in_reset_s;
    CORE_HALT && IO_PULLUP_FORCE && STACK_CLEAR;
  endsequence

  sequence pin_low_s;
    !RESET_N_IN;
  endsequence

  pin_halt_a: assert property (pin_low_s |-> ##[1:6] in_reset_s)
    else $error("pin low but core not held");
  wd_halt_a: assert property (WDOG_END_COUNT |-> ##[1:6] (CORE_HALT && WDOG_RELOAD))
    else $error("watchdog end without reset");
  por_pin_a: assert property (POR_DETECT |-> ##[1:6] (RESET_N_OE && !RESET_N_OUT))
    else $error("power-on not driving pin low");
  stab_wait_a: assert property ($fell(CORE_HALT) |-> halt_cnt_q >= STAB_CYCLES)
    else $error("reset released before delay");
  vec_load_a: assert property (PC_LOAD_STROBE |-> PROGRAM_COUNTER_LOAD == 12'hFFE)
    else $error("wrong reset vector");
  nmi_set_a: assert property (PC_LOAD_STROBE |-> ##[0:1] NMI_MODE)
    else $error("nmi mode not set after reset");
  return_from_interrupt_serve_a: assert property (RETURN_FROM_INTERRUPT_DONE && IRQ_PENDING && NMI_MODE && !CORE_HALT |-> ##[0:1] SERVICE_PENDING)
    else $error("pending interrupt not serviced");
  osc_hold_a: assert property (OSC_RESTART |-> in_reset_s)
    else $error("oscillator restart outside reset");
  init_vals_a: assert property (PERIPH_LOAD |-> PERIPH_INIT == INIT_EXP)
    else $error("wrong peripheral reset values");
endmodule

bind mrs_reset_seq mrs_seq_chk #(.STAB_CYCLES(STAB_CYCLES)) i_mrs_seq_chk (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .RESET_N_IN(RESET_N_IN), .POR_DETECT(POR_DETECT),
  .WDOG_END_COUNT(WDOG_END_COUNT), .RETURN_FROM_INTERRUPT_DONE(RETURN_FROM_INTERRUPT_DONE), .IRQ_PENDING(IRQ_PENDING),
  .RESET_N_OUT(RESET_N_OUT), .RESET_N_OE(RESET_N_OE), .CORE_HALT(CORE_HALT),
  .IO_PULLUP_FORCE(IO_PULLUP_FORCE), .OSC_RESTART(OSC_RESTART), .STACK_CLEAR(STACK_CLEAR),
  .PROGRAM_COUNTER_LOAD(PROGRAM_COUNTER_LOAD), .PC_LOAD_STROBE(PC_LOAD_STROBE), .NMI_MODE(NMI_MODE),
  .SERVICE_PENDING(SERVICE_PENDING), .WDOG_RELOAD(WDOG_RELOAD), .PERIPH_LOAD(PERIPH_LOAD),
  .PERIPH_INIT(PERIPH_INIT)
);

// ===== sim/tb.sv
// Bench for the reset sequencer: every reset source, APB reads, interrupt return.
// Assumes the board model and the bound checker are compiled first.
`include "mrs_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mrs_pkg::*;
  localparam int STAB_C = 8;
  localparam logic [79:0] INIT_EXP = 80'h00000002000000FE7F40;
  // Expected cause per source, five bits each {swrst, lvd, wdog, por, pin}
  localparam logic [29:0] CAUSE_EXP = {5'h10, 5'h08, 5'h02, 5'h04, 5'h01, 5'h01};
  logic CORE_CLK, SYS_RST, CLK_EN, POR_DETECT, LVD_BELOW_REF, LVD_ABOVE_POR_REF, WDOG_END_COUNT;
  logic MAIN_OSC_RUNNING, CPU_STOP_MODE, RETURN_FROM_INTERRUPT_DONE, IRQ_PENDING, PSEL, PENABLE, PWRITE, press;
  logic RESET_N_IN, PREADY, PSLVERR, RESET_N_OUT, RESET_N_OE, CORE_HALT, IO_PULLUP_FORCE;
  logic OSC_RESTART, STACK_CLEAR, PC_LOAD_STROBE, NMI_MODE, SERVICE_PENDING, WDOG_RELOAD, PERIPH_LOAD;
  logic [11:0] PADDR, PROGRAM_COUNTER_LOAD;
  logic [31:0] PWDATA, PRDATA, rd;
  mrs_init_vals_t PERIPH_INIT;
  mrs_cause_t RESET_CAUSE;
  logic err, sp;
  int mismatches, tests_run, n;

  mrs_reset_seq #(.STAB_CYCLES(STAB_C), .STRETCH_CYCLES(2)) i_mrs_reset_seq (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .RESET_N_IN(RESET_N_IN),
    .POR_DETECT(POR_DETECT), .LVD_BELOW_REF(LVD_BELOW_REF), .LVD_ABOVE_POR_REF(LVD_ABOVE_POR_REF),
    .WDOG_END_COUNT(WDOG_END_COUNT), .MAIN_OSC_RUNNING(MAIN_OSC_RUNNING), .CPU_STOP_MODE(CPU_STOP_MODE),
    .RETURN_FROM_INTERRUPT_DONE(RETURN_FROM_INTERRUPT_DONE), .IRQ_PENDING(IRQ_PENDING), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RESET_N_OUT(RESET_N_OUT), .RESET_N_OE(RESET_N_OE), .CORE_HALT(CORE_HALT),
    .IO_PULLUP_FORCE(IO_PULLUP_FORCE), .OSC_RESTART(OSC_RESTART), .STACK_CLEAR(STACK_CLEAR),
    .PROGRAM_COUNTER_LOAD(PROGRAM_COUNTER_LOAD), .PC_LOAD_STROBE(PC_LOAD_STROBE), .NMI_MODE(NMI_MODE),
    .SERVICE_PENDING(SERVICE_PENDING), .WDOG_RELOAD(WDOG_RELOAD), .PERIPH_LOAD(PERIPH_LOAD),
    .PERIPH_INIT(PERIPH_INIT), .RESET_CAUSE(RESET_CAUSE)
  );

  mrs_board i_mrs_board (.press(press), .dev_out(RESET_N_OUT), .dev_oe(RESET_N_OE), .pin(RESET_N_IN));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One APB transfer, held until PREADY is sampled high
  // A missing answer is caught by the watchdog process
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do
      @(posedge CORE_CLK);
    while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic to_init();
    n = 0;
    while (PC_LOAD_STROBE !== 1'b1 && n < 400)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    chk("init strobe", 1'b1, PC_LOAD_STROBE);
    chk("vector", 12'hFFE, PROGRAM_COUNTER_LOAD);
  endtask

  // The pulse is registered: it stands in the cycle after the return is taken
  task automatic return_from_interrupt(input logic pend);
    RETURN_FROM_INTERRUPT_DONE <= 1'b1;
    IRQ_PENDING <= pend;
    @(posedge CORE_CLK);
    RETURN_FROM_INTERRUPT_DONE <= 1'b0;
    IRQ_PENDING <= 1'b0;
    @(posedge CORE_CLK);
    sp = SERVICE_PENDING;
    @(posedge CORE_CLK);
  endtask

  // Sources: 0 pin held, 1 pin pulse in stop, 2 watchdog, 3 power-on, 4 low voltage, 5 software
  task automatic hit(input int s);
    int k;
    k = 0;
    apb(1'b1, `MRS_OFS_CAUSE, 32'h1F);
    if (s == 4)
      apb(1'b1, `MRS_OFS_CTRL, 32'h3);
    if (s == 5)
      apb(1'b1, `MRS_OFS_CTRL, 32'h1);
    CPU_STOP_MODE <= (s == 1);
    press <= (s < 2);
    WDOG_END_COUNT <= (s == 2);
    POR_DETECT <= (s == 3);
    LVD_BELOW_REF <= (s == 4);
    LVD_ABOVE_POR_REF <= (s != 4);
    @(posedge CORE_CLK);
    press <= (s == 0);
    WDOG_END_COUNT <= 1'b0;
    while (CORE_HALT !== 1'b1 && k++ < 20)
      @(posedge CORE_CLK);
    chk("halt", 1'b1, CORE_HALT);
    chk("pull-ups", 1'b1, IO_PULLUP_FORCE);
    chk("watchdog reload", 1'b1, WDOG_RELOAD);
    chk("reset values", INIT_EXP, PERIPH_INIT);
    if (s == 0 || s == 3 || s == 4)
    begin
      repeat (20) @(posedge CORE_CLK);
      chk("held", 1'b1, CORE_HALT);
      if (s > 2)
        chk("pin driven", 1'b1, RESET_N_OE);
      press <= 1'b0;
      POR_DETECT <= 1'b0;
      LVD_BELOW_REF <= 1'b0;
      // Pin and power-on release at once; waiting here would miss the init strobe
      if (s == 4)
      begin
        repeat (20) @(posedge CORE_CLK);
        chk("low voltage latched", 1'b1, CORE_HALT);
      end
      LVD_ABOVE_POR_REF <= 1'b1;
    end
    to_init();
    chk("release delay", 1'b1, n >= STAB_C);
    chk("cause", CAUSE_EXP[s*5 +: 5], RESET_CAUSE);
    CPU_STOP_MODE <= 1'b0;
    $display("test source %0d done", s);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial
  begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // The whole run needs well under 2000 cycles
  initial
  begin
    #50us;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    SYS_RST = 1'b1;
    CLK_EN = 1'b1;
    MAIN_OSC_RUNNING = 1'b1;
    LVD_ABOVE_POR_REF = 1'b1;
    {POR_DETECT, LVD_BELOW_REF, WDOG_END_COUNT, CPU_STOP_MODE, RETURN_FROM_INTERRUPT_DONE, IRQ_PENDING} = 6'h00;
    {PSEL, PENABLE, PWRITE, press, PADDR, PWDATA} = 48'h0;
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    to_init();
    chk("power-on delay", 1'b1, n >= STAB_C);
    repeat (2) @(posedge CORE_CLK);
    chk("nmi mode", 1'b1, NMI_MODE);
    chk("halt released", 1'b0, CORE_HALT);
    apb(1'b0, `MRS_OFS_VECT, 32'h0);
    chk("vector reg", 32'hFFE, rd);
    apb(1'b0, `MRS_OFS_CAUSE, 32'h0);
    chk("cause reg", 32'h2, rd);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 1'b1, err);
    apb(1'b0, `MRS_OFS_CTRL, 32'h0);
    chk("ctrl nmi", 32'h6, rd & 32'h6);
    return_from_interrupt(1'b1);
    chk("service", 1'b1, sp);
    chk("nmi cleared", 1'b0, NMI_MODE);
    return_from_interrupt(1'b0);
    chk("no service", 1'b0, sp);
    $display("test start-up done");
    apb(1'b1, `MRS_OFS_CTRL, 32'h2);
    LVD_BELOW_REF <= 1'b1;
    repeat (10) @(posedge CORE_CLK);
    chk("detector off", 1'b0, CORE_HALT);
    LVD_BELOW_REF <= 1'b0;
    @(posedge CORE_CLK);
    $display("test detector off done");
    for (int s = 0; s < 6; s++)
      hit(s);
    wrap_up();
  end
endmodule
